// ===== src/mpb_pkg.sv
// constants and types shared by the pin bus and power control block
// Notes on behaviour
// - port zero open-drain, ones float
// - bus on port zero drives ones actively
// - ports one to three weakly pulled up
// - port one bits feed third timer inputs
// - port two drives high address externally
// - short pointer access keeps port two latch
// - port three carries alternate functions and strobes
// - reset pin held two machine cycles
// - reset forces ports one to three high
// - latch strobe at sixth rate, one skipped
// - program strobe twice, two skipped on data
// - no program strobe for internal fetch
// - select pin picks internal or external fetch
// - idle gates cpu clock, powerdown stops oscillator
// - powerdown keeps ram, idle keeps peripherals
// - power control at 87 hex, byte only
// - powerdown and idle bits, powerdown wins
// - power control resets to zero, flags inert
// - enabled interrupt clears idle bit
package mpb_pkg;
  localparam int OSC_PER_MC = 12;
  localparam int RST_MC = 2;
  localparam int RST_HOLD_CLKS = RST_MC * OSC_PER_MC;
  localparam int SYNC_W = 34;
  localparam logic [3:0] PH_LAST = 4'hB;
  localparam logic [3:0] PH_SLOT_B = 4'h6;
  localparam logic [3:0] LOC_ALE_LO = 4'h1;
  localparam logic [3:0] LOC_ALE_HI = 4'h2;
  localparam logic [3:0] LOC_RD_LO = 4'h3;
  localparam logic [3:0] LOC_RD_HI = 4'h5;
  localparam logic [3:0] PH_STB_LO = 4'h3;
  localparam logic [3:0] PH_STB_HI = 4'hA;
  localparam logic [3:0] PH_DATA_SAMPLE = 4'hA;
  localparam logic [15:0] INT_ROM_TOP = 16'h1FFF;
  localparam logic [7:0] PWR_CTRL_ADDR = 8'h87;
  localparam logic [7:0] PWR_CTRL_RESET = 8'h00;
  localparam logic [7:0] PWR_CTRL_WMASK = 8'h8F;
  localparam logic [7:0] PORT_RESET = 8'hFF;
  localparam int IDLE_BIT = 0;
  localparam int PWRDN_BIT = 1;
  localparam int BAUD_BIT = 7;
  localparam int P1_TC_COUNT = 0;
  localparam int P1_TC_TRIG = 1;
  localparam int P3_RXD = 0;
  localparam int P3_TXD = 1;
  localparam int P3_IRQ_A = 2;
  localparam int P3_IRQ_B = 3;
  localparam int P3_TA = 4;
  localparam int P3_TB = 5;
  localparam int P3_WR = 6;
  localparam int P3_RD = 7;
  typedef enum logic [1:0] {K_NONE, K_FETCH, K_RD, K_WR} mpb_kind_type;
endpackage : mpb_pkg

// ===== src/mpb_sync.sv
// two flip-flop synchroniser for the pin inputs
`timescale 1ns/1ps
module mpb_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  if (W < 1) begin : g_chk
    $error("mpb_sync width must be at least one");
  end

  // the first stage feeds only the second
  always_ff @(posedge mclk) begin
    if (srst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : mpb_sync

// ===== src/mpb_pin_bus.sv
// port pins, external memory bus sequencer, reset pin and power control
`timescale 1ns/1ps
module mpb_pin_bus
  import mpb_pkg::*;
#(
  parameter logic [15:0] ROM_TOP = INT_ROM_TOP
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic rst_pin,
  input wire logic prog_source_select,
  input wire logic [7:0] p0_in,
  output logic [7:0] p0_out,
  output logic [7:0] p0_oe_n,
  input wire logic [7:0] p1_in,
  output logic [7:0] p1_out,
  output logic [7:0] p1_oe_n,
  input wire logic [7:0] port2_in,
  output logic [7:0] port2_out,
  output logic [7:0] port2_oe_n,
  input wire logic [7:0] p3_in,
  output logic [7:0] p3_out,
  output logic [7:0] p3_oe_n,
  output logic addr_latch_strobe,
  output logic prog_read_strobe_n,
  output logic core_reset,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic osc_run,
  input wire logic fetch_req,
  input wire logic [15:0] fetch_addr,
  output logic fetch_done,
  output logic fetch_ext,
  output logic [7:0] fetch_data,
  input wire logic data_req,
  input wire logic data_write,
  input wire logic ext_move_wide_ptr,
  input wire logic [15:0] data_addr,
  input wire logic [7:0] data_wdata,
  output logic data_done,
  output logic [7:0] data_rdata,
  input wire logic [3:0] port_wr,
  input wire logic [7:0] port_wdata,
  output logic [31:0] port_level,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rd_data,
  input wire logic irq_wake,
  input wire logic serial_tx,
  output logic baud_double,
  output logic serial_rx,
  output logic timer_c_count_in,
  output logic timer_c_trigger_in,
  output logic ext_irq_a,
  output logic ext_irq_b,
  output logic timer_a_count_in,
  output logic timer_b_count_in
);
  localparam int CW = $clog2(RST_HOLD_CLKS + 1);
  localparam logic [CW-1:0] RST_HOLD = CW'(RST_HOLD_CLKS);

  if (RST_HOLD_CLKS < 1) begin : g_chk
    $error("reset hold count must be at least one");
  end

  logic [SYNC_W-1:0] sync_q;
  logic [7:0] p0_s, p1_s, p3_s;
  logic rst_s, sel_s;

  ////////////////////////////////////////////////////////////////////////////
  mpb_sync #(.W(SYNC_W)) u_sync (
    .mclk(mclk),
    .srst(srst),
    .d({prog_source_select, rst_pin, p3_in, port2_in, p1_in, p0_in}),
    .q(sync_q)
  );

  assign p0_s = sync_q[7:0];
  assign p1_s = sync_q[15:8];
  assign p3_s = sync_q[31:24];
  assign rst_s = sync_q[32];
  assign sel_s = sync_q[33];
  assign port_level = sync_q[31:0];

  ////////////////////////////////////////////////////////////////////////////
  // reset pin qualifier
  logic [CW-1:0] rcnt_r, rcnt_nxt;
  logic core_reset_nxt;

  always_comb begin
    rcnt_nxt = rcnt_r;
    core_reset_nxt = core_reset;
    if (srst || !rst_s) begin
      rcnt_nxt = '0;
      core_reset_nxt = 1'b0;
    end else if (rcnt_r != RST_HOLD) begin
      rcnt_nxt = rcnt_r + CW'(1);
    end
    if (!srst && rst_s && rcnt_nxt == RST_HOLD) begin
      core_reset_nxt = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    rcnt_r <= rcnt_nxt;
    core_reset <= core_reset_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // power control register and clock enables
  logic ireset;
  logic [7:0] pwr_ctrl_r, pwr_ctrl_nxt, sfr_rd_nxt;
  logic pwr_hit, pwrdn, idle, running;

  assign ireset = srst | core_reset;
  assign pwr_hit = sfr_addr == PWR_CTRL_ADDR;
  assign pwrdn = pwr_ctrl_r[PWRDN_BIT];
  assign idle = pwr_ctrl_r[IDLE_BIT] & ~pwrdn;
  assign running = ~pwrdn & ~idle;

  always_comb begin
    pwr_ctrl_nxt = pwr_ctrl_r;
    sfr_rd_nxt = pwr_hit ? pwr_ctrl_r : 8'h00;
    if (ireset) begin
      pwr_ctrl_nxt = PWR_CTRL_RESET;
    end else if (sfr_wr && pwr_hit) begin
      // whole byte only; reserved bits stay zero
      pwr_ctrl_nxt = sfr_wdata & PWR_CTRL_WMASK;
    end else if (irq_wake && pwr_ctrl_r[IDLE_BIT]) begin
      pwr_ctrl_nxt[IDLE_BIT] = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    pwr_ctrl_r <= pwr_ctrl_nxt;
    sfr_rd_data <= sfr_rd_nxt;
    baud_double <= pwr_ctrl_nxt[BAUD_BIT];
    cpu_clk_en <= ~pwr_ctrl_nxt[PWRDN_BIT] & ~pwr_ctrl_nxt[IDLE_BIT];
    periph_clk_en <= ~pwr_ctrl_nxt[PWRDN_BIT];
    osc_run <= ~pwr_ctrl_nxt[PWRDN_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // machine cycle sequencer and pin drivers
  logic [3:0] phase_r, phase_nxt, loc_nxt;
  mpb_kind_type kind_r, kind_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic [7:0] wdat_r, wdat_nxt;
  logic wide_r, wide_nxt;
  logic [7:0] latch_r [0:3];
  logic [7:0] latch_nxt [0:3];
  logic fdone_nxt, fext_nxt, ddone_nxt;
  logic [7:0] fdata_nxt, ddata_nxt;
  logic ale_nxt, prog_read_strobe_n_nxt, is_data_nxt, ext_f, rd_n, wr_n;
  logic [7:0] p0o, p0e, p1o, p1e, p2o, p2e, p3o, p3e, p3eff;

  always_comb begin
    phase_nxt = phase_r;
    kind_nxt = kind_r;
    addr_nxt = addr_r;
    wdat_nxt = wdat_r;
    wide_nxt = wide_r;
    fdone_nxt = 1'b0;
    fext_nxt = fetch_ext;
    fdata_nxt = fetch_data;
    ddone_nxt = 1'b0;
    ddata_nxt = data_rdata;
    ext_f = ~sel_s | (fetch_addr > ROM_TOP);
    for (int i = 0; i < 4; i++) begin
      latch_nxt[i] = latch_r[i];
      if (ireset) begin
        latch_nxt[i] = PORT_RESET;
      end else if (port_wr[i]) begin
        latch_nxt[i] = port_wdata;
      end
    end
    if (ireset || !running) begin
      // entering a low power mode abandons the cycle in flight
      phase_nxt = '0;
      kind_nxt = K_NONE;
    end else begin
      phase_nxt = (phase_r == PH_LAST) ? 4'h0 : phase_r + 4'h1;
      if (kind_r == K_FETCH && (phase_r == LOC_RD_HI || phase_r == LOC_RD_HI + PH_SLOT_B)) begin
        fdone_nxt = 1'b1;
        fdata_nxt = p0_s;
      end
      if (kind_r == K_RD && phase_r == PH_DATA_SAMPLE) begin
        ddone_nxt = 1'b1;
        ddata_nxt = p0_s;
      end
      if (kind_r == K_WR && phase_r == PH_DATA_SAMPLE) begin
        ddone_nxt = 1'b1;
      end
      if (phase_nxt == 4'h0 && data_req) begin
        kind_nxt = data_write ? K_WR : K_RD;
        addr_nxt = data_addr;
        wdat_nxt = data_wdata;
        wide_nxt = ext_move_wide_ptr;
      end else if (phase_nxt == 4'h0 ||
                   (phase_nxt == PH_SLOT_B && kind_r != K_RD && kind_r != K_WR)) begin
        kind_nxt = K_NONE;
        if (fetch_req) begin
          addr_nxt = fetch_addr;
          fext_nxt = ext_f;
          if (ext_f) begin
            kind_nxt = K_FETCH;
          end else begin
            fdone_nxt = 1'b1;
          end
        end
      end
    end
  end

  always_comb begin
    is_data_nxt = kind_nxt == K_RD || kind_nxt == K_WR;
    loc_nxt = (phase_nxt >= PH_SLOT_B) ? phase_nxt - PH_SLOT_B : phase_nxt;
    // second strobe of a data cycle is dropped
    ale_nxt = loc_nxt >= LOC_ALE_LO && loc_nxt <= LOC_ALE_HI &&
              !(is_data_nxt && phase_nxt >= PH_SLOT_B);
    // no fetch slot inside a data cycle, so both reads vanish
    prog_read_strobe_n_nxt = !(kind_nxt == K_FETCH && loc_nxt >= LOC_RD_LO &&
                   loc_nxt <= LOC_RD_HI);
    rd_n = !(kind_nxt == K_RD && phase_nxt >= PH_STB_LO && phase_nxt <= PH_STB_HI);
    wr_n = !(kind_nxt == K_WR && phase_nxt >= PH_STB_LO && phase_nxt <= PH_STB_HI);
    if (pwrdn) begin
      ale_nxt = 1'b0;
      prog_read_strobe_n_nxt = 1'b0;
    end else if (idle) begin
      ale_nxt = 1'b1;
      prog_read_strobe_n_nxt = 1'b1;
    end
    // open drain: only zeros are driven
    p0o = latch_nxt[0];
    p0e = latch_nxt[0];
    if (kind_nxt != K_NONE && loc_nxt <= LOC_ALE_HI &&
        !(is_data_nxt && phase_nxt >= PH_SLOT_B)) begin
      p0o = addr_nxt[7:0];
      p0e = 8'h00;
    end else if (kind_nxt == K_WR && phase_nxt >= PH_STB_LO) begin
      p0o = wdat_nxt;
      p0e = 8'h00;
    end else if (kind_nxt != K_NONE) begin
      p0o = 8'hFF;
      p0e = 8'hFF;
    end
    p1o = latch_nxt[1];
    p1e = latch_nxt[1];
    if (kind_nxt == K_FETCH || (is_data_nxt && wide_nxt)) begin
      p2o = addr_nxt[15:8];
      p2e = 8'h00;
    end else begin
      p2o = latch_nxt[2];
      p2e = latch_nxt[2];
    end
    p3eff = latch_nxt[3];
    p3eff[P3_WR] = latch_nxt[3][P3_WR] & wr_n;
    p3eff[P3_RD] = latch_nxt[3][P3_RD] & rd_n;
    p3eff[P3_TXD] = latch_nxt[3][P3_TXD] & serial_tx;
    p3o = p3eff;
    p3e = p3eff;
    if (rst_s || ireset) begin
      // released to the pullups as soon as the pin is seen high
      p1o = PORT_RESET;
      p1e = PORT_RESET;
      p2o = PORT_RESET;
      p2e = PORT_RESET;
      p3o = PORT_RESET;
      p3e = PORT_RESET;
    end
  end

  always_ff @(posedge mclk) begin
    phase_r <= phase_nxt;
    kind_r <= kind_nxt;
    addr_r <= addr_nxt;
    wdat_r <= wdat_nxt;
    wide_r <= wide_nxt;
    for (int i = 0; i < 4; i++) begin
      latch_r[i] <= latch_nxt[i];
    end
    fetch_done <= fdone_nxt;
    fetch_ext <= fext_nxt;
    fetch_data <= fdata_nxt;
    data_done <= ddone_nxt;
    data_rdata <= ddata_nxt;
    addr_latch_strobe <= ale_nxt;
    prog_read_strobe_n <= prog_read_strobe_n_nxt;
    p0_out <= p0o;
    p0_oe_n <= p0e;
    p1_out <= p1o;
    p1_oe_n <= p1e;
    port2_out <= p2o;
    port2_oe_n <= p2e;
    p3_out <= p3o;
    p3_oe_n <= p3e;
  end

  ////////////////////////////////////////////////////////////////////////////
  // alternate pin inputs
  always_ff @(posedge mclk) begin
    timer_c_count_in <= p1_s[P1_TC_COUNT];
    timer_c_trigger_in <= p1_s[P1_TC_TRIG];
    serial_rx <= p3_s[P3_RXD];
    ext_irq_a <= p3_s[P3_IRQ_A];
    ext_irq_b <= p3_s[P3_IRQ_B];
    timer_a_count_in <= p3_s[P3_TA];
    timer_b_count_in <= p3_s[P3_TB];
  end
endmodule : mpb_pin_bus

// ===== sim/mpb_monitor.sv
// pin bus and power control checker
`timescale 1ns/1ps
module mpb_monitor
  import mpb_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic rst_pin,
  input wire logic [7:0] p1_out,
  input wire logic [7:0] port2_out,
  input wire logic [7:0] p3_out,
  input wire logic addr_latch_strobe,
  input wire logic prog_read_strobe_n,
  input wire logic core_reset,
  input wire logic cpu_clk_en,
  input wire logic periph_clk_en,
  input wire logic osc_run,
  input wire logic fetch_done,
  input wire logic fetch_ext,
  input wire logic data_done,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rd_data,
  input wire logic irq_wake
);
  wire ale = addr_latch_strobe;
  wire prs_n = prog_read_strobe_n;
  // idle, powerdown and core reset all stop the bus phases and clear them to zero
  wire run = osc_run && cpu_clk_en && !core_reset;
  wire pw = sfr_wr && sfr_addr == PWR_CTRL_ADDR;
  wire dstb = !p3_out[P3_RD] || !p3_out[P3_WR];
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////////////////////
  a_ale_width: assert property ($rose(ale) && run |=> ale ##1 (!ale || !cpu_clk_en))
    else $error("latch strobe width wrong");
  a_ale_gap: assert property ($fell(ale) && run |-> ##[4:10] ($rose(ale) || !run))
    else $error("latch strobe gap wrong");
  a_strobe_width: assert property ($fell(prs_n) && run |=> !prs_n ##1 !prs_n ##1 prs_n)
    else $error("program strobe width wrong");
  a_int_quiet: assert property (fetch_done && !fetch_ext |-> prs_n && $past(prs_n))
    else $error("program strobe on internal fetch");
  a_data_quiet: assert property (dstb && run |-> prs_n && !ale)
    else $error("strobe during data access");
  a_data_done: assert property ($fell(p3_out[P3_RD]) && run |-> ##[7:9] data_done)
    else $error("data read not finished");
  a_pd_entry: assert property (pw && sfr_wdata[PWRDN_BIT] |=> !osc_run && !cpu_clk_en)
    else $error("powerdown not entered");
  a_idle_wake: assert property (irq_wake && !cpu_clk_en && osc_run |-> ##[1:3] cpu_clk_en)
    else $error("idle not left");
  a_sfr_other: assert property (sfr_addr != PWR_CTRL_ADDR |=> sfr_rd_data == 8'h00)
    else $error("unmapped read not zero");
  a_pin_force: assert property (rst_pin [*4] |-> (p1_out & port2_out & p3_out) == PORT_RESET)
    else $error("ports not forced high");
endmodule : mpb_monitor

bind mpb_pin_bus mpb_monitor i_mpb_monitor (.*);

// ===== sim/mpb_ext_mem.sv
// external program and data memory on the multiplexed bus
`timescale 1ns/1ps
module mpb_ext_mem (
  input wire logic mclk,
  input wire logic ale,
  input wire logic prd_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [15:0] bus,
  output logic [7:0] q,
  output logic [15:0] wa,
  output logic [7:0] wd
);
  logic [15:0] a;
  logic [7:0] flt = 8'h5A;
  // address taken from port two and port zero while the latch strobe is high
  always @(posedge mclk) begin
    flt <= ~flt;
    if (ale)
      a <= bus;
    if (!wr_n) begin
      wa <= a;
      wd <= bus[7:0];
    end
  end
  // a released bus toggles, so a stale byte never reads as valid
  assign q = (!prd_n || !rd_n) ? a[7:0] ^ a[15:8] : flt;
endmodule : mpb_ext_mem

// ===== sim/tb_top.sv
// self-checking bench for the pin bus block
`timescale 1ns/1ps
module tb_top
  import mpb_pkg::*;
;
  logic mclk = 0, srst = 1, rst_pin = 0, prog_source_select = 1, fetch_req = 0;
  logic data_req = 0, data_write = 0, ext_move_wide_ptr = 0, sfr_wr = 0, irq_wake = 0;
  logic serial_tx = 1;
  logic [15:0] fetch_addr = '0, data_addr = '0, wa;
  logic [7:0] data_wdata = '0, port_wdata = '0, sfr_addr = '0, sfr_wdata = '0, p1_dn = '0;
  logic [7:0] p3_dn = '0, q, wd, fetch_data, data_rdata, sfr_rd_data;
  logic [7:0] p0_out, p0_oe_n, p1_out, p1_oe_n, port2_out, port2_oe_n, p3_out, p3_oe_n;
  logic [3:0] port_wr = '0;
  logic [31:0] port_level;
  logic addr_latch_strobe, prog_read_strobe_n, core_reset, cpu_clk_en, periph_clk_en, osc_run;
  logic fetch_done, fetch_ext, data_done, baud_double, serial_rx, timer_c_count_in;
  logic timer_c_trigger_in, ext_irq_a, ext_irq_b, timer_a_count_in, timer_b_count_in;
  int mismatches = 0, compares = 0, cyc = 0;
  wire [7:0] p0w = ~p0_oe_n & p0_out | p0_oe_n & q;
  wire [7:0] p1w = (p1_oe_n | p1_out) & ~p1_dn;
  wire [7:0] p2w = port2_oe_n | port2_out;
  wire [7:0] p3w = (p3_oe_n | p3_out) & ~p3_dn;
  mpb_pin_bus i_mpb_pin_bus (.*, .p0_in(p0w), .p1_in(p1w), .port2_in(p2w), .p3_in(p3w));
  mpb_ext_mem i_mpb_ext_mem (.mclk(mclk), .ale(addr_latch_strobe), .prd_n(prog_read_strobe_n),
    .rd_n(p3w[P3_RD]), .wr_n(p3w[P3_WR]), .bus({p2w, p0w}), .q(q), .wa(wa), .wd(wd));
  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(negedge mclk);
  endtask : wt
  task automatic pwr(input logic [3:0] w, input logic [7:0] d);
    port_wdata = d;
    port_wr = w;
    wt(1);
    port_wr = '0;
    wt(5);
  endtask : pwr
  task automatic do_reset();
    srst = 1;
    wt(6);
    srst = 0;
    wt(2);
  endtask : do_reset
  task automatic sfr(input logic [7:0] d);
    sfr_addr = PWR_CTRL_ADDR;
    sfr_wdata = d;
    sfr_wr = 1;
    wt(1);
    sfr_wr = 0;
    wt(1);
  endtask : sfr
  // request stays up until done; the repeat it may launch ends inside the pause
  task automatic fetch(input logic [15:0] a, input logic e, input logic [7:0] d);
    fetch_addr = a;
    fetch_req = 1;
    // polled at the falling edge, where the one-cycle pulse has settled
    for (int i = 0; i < 40 && !fetch_done; i++) @(negedge mclk);
    chk(fetch_done, 1);
    wt(1);
    fetch_req = 0;
    chk({fetch_ext, e ? fetch_data : 8'h00}, {e, d});
    wt(14);
  endtask : fetch
  task automatic dacc(input logic w, input logic wide, input logic [15:0] a, input logic [7:0] d);
    {data_write, ext_move_wide_ptr, data_addr, data_wdata} = {w, wide, a, d};
    data_req = 1;
    for (int i = 0; i < 40 && !data_done; i++) @(negedge mclk);
    chk(data_done, 1);
    wt(1);
    data_req = 0;
    wt(14);
  endtask : dacc
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_pins();
    sfr_addr = 8'h88;
    wt(2);
    chk(sfr_rd_data, 8'h00);
    chk({p3_out, port2_out}, 16'hFFFF);
    pwr(4'h3, 8'hF0);
    chk({port_level[15:8], port_level[3:0]}, 12'hF00);
    pwr(4'h3, 8'hFF);
    {p1_dn, p3_dn, serial_tx} = {8'h03, 8'h3D, 1'h0};
    wt(6);
    chk({timer_c_trigger_in, timer_c_count_in}, 16'h0);
    chk({timer_b_count_in, timer_a_count_in, ext_irq_b, ext_irq_a, serial_rx}, 16'h0);
    chk(p3_out[P3_TXD], 1'h0);
    {p1_dn, p3_dn, serial_tx} = {8'h00, 8'h00, 1'h1};
    wt(6);
    chk({timer_c_trigger_in, timer_c_count_in}, 16'h3);
    $display("test pins done");
  endtask : t_pins
  task automatic t_bus();
    fetch(16'h0100, 0, 8'h00);
    fetch(16'h2000, 1, 8'h20);
    prog_source_select = 0;
    // the select pin passes two flops before the next slot may use it
    wt(3);
    fetch(16'h0010, 1, 8'h10);
    prog_source_select = 1;
    dacc(0, 1, 16'h1234, 8'h00);
    chk(data_rdata, 8'h26);
    dacc(1, 1, 16'h3456, 8'hC3);
    chk({wa[15:8], wd}, 16'h34C3);
    pwr(4'h4, 8'h7E);
    dacc(1, 0, 16'h0055, 8'h3C);
    chk(wa, 16'h7E55);
    pwr(4'h4, 8'hFF);
    $display("test bus done");
  endtask : t_bus
  task automatic t_power();
    sfr(8'h0D);
    chk({osc_run, periph_clk_en, cpu_clk_en, sfr_rd_data}, 16'h60D);
    chk({addr_latch_strobe, prog_read_strobe_n}, 16'h3);
    irq_wake = 1;
    wt(4);
    irq_wake = 0;
    chk({cpu_clk_en, sfr_rd_data}, 16'h10C);
    sfr(8'hF3);
    chk({osc_run, cpu_clk_en, baud_double}, 16'h1);
    do_reset();
    chk(sfr_rd_data, PWR_CTRL_RESET);
    $display("test power done");
  endtask : t_power
  task automatic t_rst();
    pwr(4'h2, 8'h55);
    rst_pin = 1;
    wt(10);
    rst_pin = 0;
    wt(3);
    chk(core_reset, 1'h0);
    rst_pin = 1;
    wt(30);
    chk({core_reset, p1_out}, 16'h1FF);
    rst_pin = 0;
    wt(5);
    chk({core_reset, p1_out}, 16'h0FF);
    $display("test reset pin done");
  endtask : t_rst
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict
  initial begin
    do_reset();
    t_pins();
    t_bus();
    t_power();
    t_rst();
    give_verdict();
  end
endmodule : tb_top
